// >>> pkg/cfgul_cfg.svh
// Constants of the configuration port unlock gate
`ifndef CFGUL_CFG_SVH
`define CFGUL_CFG_SVH
// ----------------------------------------
// Port addresses
// ----------------------------------------
`define CFGUL_IDX_PRI   10'h3f0
`define CFGUL_DAT_PRI   10'h3f1
`define CFGUL_IDX_ALT   10'h370
`define CFGUL_DAT_ALT   10'h371
// ----------------------------------------
// Key bytes and register range
// ----------------------------------------
`define CFGUL_KEY_ENTER 8'h55
`define CFGUL_KEY_EXIT  8'haa
`define CFGUL_IDX_MAX   8'h29
`define CFGUL_NREG      42
`define CFGUL_REG_RST   8'h00
`endif

// >>> pkg/cfgul_pkg.sv
// Types of the configuration port unlock gate
package cfgul_pkg;
  typedef enum logic [1:0] {
    CFGUL_LOCKED,
    CFGUL_KEY1,
    CFGUL_OPEN
  } cfgul_state_t;
endpackage

// >>> design/cfgul_gate.sv
// Configuration access gate with strap base select and two-write unlock key
`timescale 1ns/1ps
`include "cfgul_cfg.svh"
module cfgul_gate #(
  parameter int NREG = `CFGUL_NREG
) (
  // Clock, reset, enable
  input  wire logic       clk_sys,
  input  wire logic       rst_b,
  input  wire logic       clk_en,
  // Strap
  input  wire logic       config_base_strap,
  // Host I/O access, one cycle strobes
  input  wire logic [9:0] io_addr,
  input  wire logic [7:0] io_wdata,
  input  wire logic       io_wr,
  input  wire logic       io_rd,
  // Read answer and status
  output logic [7:0]      io_rdata_q,
  output logic            io_rvalid_q,
  output logic            cfg_mode_q,
  output logic            base_alt_q,
  output logic [7:0]      cfg_index_q,
  output logic [8*NREG-1:0] config_register_set
);

  cfgul_pkg::cfgul_state_t state_q;
  logic       strap_done_q;
  logic [7:0] regs_q [NREG];
  logic [9:0] idx_port;
  logic [9:0] dat_port;
  logic       wr_idx;
  logic       wr_dat;
  logic       rd_dat;
  logic       idx_ok;

  // --------------------------------------
  // Port decode
  // --------------------------------------
  // Selected pair from captured strap
  assign idx_port = base_alt_q ? `CFGUL_IDX_ALT : `CFGUL_IDX_PRI;
  assign dat_port = base_alt_q ? `CFGUL_DAT_ALT : `CFGUL_DAT_PRI;
  assign wr_idx   = io_wr && (io_addr == idx_port);
  assign wr_dat   = io_wr && (io_addr == dat_port);
  assign rd_dat   = io_rd && (io_addr == dat_port);
  assign idx_ok   = (cfg_index_q <= `CFGUL_IDX_MAX);

  // Strap capture once after reset release
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      strap_done_q <= 1'b0;
      base_alt_q   <= 1'b0;
    end else if (clk_en && !strap_done_q) begin
      strap_done_q <= 1'b1;
      base_alt_q   <= config_base_strap;
    end
  end

  // --------------------------------------
  // Unlock state machine
  // --------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      state_q <= cfgul_pkg::CFGUL_LOCKED;
    end else if (clk_en && strap_done_q && io_wr) begin
      unique case (state_q)
        cfgul_pkg::CFGUL_LOCKED: begin
          if (wr_idx && io_wdata == `CFGUL_KEY_ENTER) begin
            state_q <= cfgul_pkg::CFGUL_KEY1;
          end
        end
        cfgul_pkg::CFGUL_KEY1: begin
          if (wr_idx && io_wdata == `CFGUL_KEY_ENTER) begin
            state_q <= cfgul_pkg::CFGUL_OPEN;
          end else begin
            state_q <= cfgul_pkg::CFGUL_LOCKED;
          end
        end
        cfgul_pkg::CFGUL_OPEN: begin
          if (wr_idx && io_wdata == `CFGUL_KEY_EXIT) begin
            state_q <= cfgul_pkg::CFGUL_LOCKED;
          end
        end
        default: state_q <= cfgul_pkg::CFGUL_LOCKED;
      endcase
    end
  end

  // Mode flag mirrors the open state
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      cfg_mode_q <= 1'b0;
    end else if (clk_en) begin
      cfg_mode_q <= (state_q == cfgul_pkg::CFGUL_OPEN)
                    && !(strap_done_q && wr_idx && io_wdata == `CFGUL_KEY_EXIT);
      if (state_q == cfgul_pkg::CFGUL_KEY1 && strap_done_q && wr_idx
          && io_wdata == `CFGUL_KEY_ENTER) begin
        cfg_mode_q <= 1'b1;
      end
    end
  end

  // --------------------------------------
  // Index and register set
  // --------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      cfg_index_q <= 8'h00;
    end else if (clk_en && state_q == cfgul_pkg::CFGUL_OPEN && wr_idx
                 && io_wdata != `CFGUL_KEY_EXIT) begin
      cfg_index_q <= io_wdata;
    end
  end

  // Register storage, one entry per index
  for (genvar i = 0; i < NREG; i++) begin : g_reg
    always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
        regs_q[i] <= `CFGUL_REG_RST;
      end else if (clk_en && state_q == cfgul_pkg::CFGUL_OPEN && wr_dat
                   && cfg_index_q == 8'(i)) begin
        regs_q[i] <= io_wdata;
      end
    end
    assign config_register_set[8*i +: 8] = regs_q[i];
  end

  // Data port read answer, one cycle later
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      io_rdata_q  <= 8'h00;
      io_rvalid_q <= 1'b0;
    end else if (clk_en) begin
      io_rvalid_q <= rd_dat && state_q == cfgul_pkg::CFGUL_OPEN;
      io_rdata_q  <= (rd_dat && state_q == cfgul_pkg::CFGUL_OPEN && idx_ok)
                     ? regs_q[cfg_index_q[5:0]] : 8'h00;
    end
  end

  // --------------------------------------
  // Checks
  // --------------------------------------
  sequence s_key_pair;
    (clk_en && strap_done_q && wr_idx && io_wdata == `CFGUL_KEY_ENTER
     && state_q == cfgul_pkg::CFGUL_KEY1);
  endsequence

  a_unlock_on_key: assert property (@(posedge clk_sys) disable iff (!rst_b)
    s_key_pair |=> cfg_mode_q) else $error("second key did not open");

  a_break_restarts: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (clk_en && strap_done_q && io_wr && !wr_idx && state_q == cfgul_pkg::CFGUL_KEY1)
    |=> state_q == cfgul_pkg::CFGUL_LOCKED) else $error("foreign write kept key");

  a_exit_locks: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (clk_en && strap_done_q && cfg_mode_q && wr_idx && io_wdata == `CFGUL_KEY_EXIT)
    |=> !cfg_mode_q) else $error("exit key ignored");

  a_locked_stable: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (state_q != cfgul_pkg::CFGUL_OPEN) |=> $stable(config_register_set))
    else $error("register changed while locked");

  a_strap_held: assert property (@(posedge clk_sys) disable iff (!rst_b)
    strap_done_q |=> $stable(base_alt_q) && strap_done_q)
    else $error("strap changed after capture");

  a_reset_clear: assert property (@(posedge clk_sys)
    !rst_b |=> !cfg_mode_q && state_q == cfgul_pkg::CFGUL_LOCKED)
    else $error("reset did not lock");

  a_one_key_no_open: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (state_q == cfgul_pkg::CFGUL_LOCKED && !cfg_mode_q) |=> !cfg_mode_q)
    else $error("opened on a single key");

  a_data_write: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (clk_en && cfg_mode_q && wr_dat && cfg_index_q == 8'h00)
    |=> config_register_set[7:0] == $past(io_wdata))
    else $error("data write missed register");

  // Exit key written while open
  sequence s_exit_write;
    (clk_en && strap_done_q && wr_idx && io_wdata == `CFGUL_KEY_EXIT
     && state_q == cfgul_pkg::CFGUL_OPEN);
  endsequence

  // Index load while open, any byte but the exit key
  sequence s_index_write;
    (clk_en && state_q == cfgul_pkg::CFGUL_OPEN && wr_idx
     && io_wdata != `CFGUL_KEY_EXIT);
  endsequence

  a_exit_keeps_index: assert property (@(posedge clk_sys) disable iff (!rst_b)
    s_exit_write |=> $stable(cfg_index_q) && !cfg_mode_q)
    else $error("exit key moved the index");

  a_index_load: assert property (@(posedge clk_sys) disable iff (!rst_b)
    s_index_write |=> cfg_index_q == $past(io_wdata))
    else $error("index write not taken");

  // Strap capture and base pair decode
  a_strap_capture: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (clk_en && !strap_done_q) |=> strap_done_q && base_alt_q == $past(config_base_strap))
    else $error("strap not caught on first edge");

  a_other_pair_ignored: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (clk_en && strap_done_q && io_wr && state_q == cfgul_pkg::CFGUL_LOCKED
     && io_addr == (base_alt_q ? `CFGUL_IDX_PRI : `CFGUL_IDX_ALT))
    |=> state_q == cfgul_pkg::CFGUL_LOCKED)
    else $error("key seen at the unselected pair");

  // Index range and read answer
  a_high_index_write: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (clk_en && state_q == cfgul_pkg::CFGUL_OPEN && wr_dat && !idx_ok)
    |=> $stable(config_register_set))
    else $error("write past last register landed");

  a_high_index_read: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (clk_en && state_q == cfgul_pkg::CFGUL_OPEN && rd_dat && !idx_ok)
    |=> io_rvalid_q && io_rdata_q == 8'h00)
    else $error("read past last register not zero");

  a_locked_no_answer: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (clk_en && io_rd && state_q != cfgul_pkg::CFGUL_OPEN) |=> !io_rvalid_q)
    else $error("read answered while locked");

endmodule

// >>> sim/cfgul_host.sv
// Host processor model issuing one-cycle I/O strobes
`timescale 1ns/1ps
`include "cfgul_cfg.svh"
module cfgul_host (
  // Clock
  input  wire logic       clk_sys,
  // Host I/O access
  output logic [9:0]      io_addr,
  output logic [7:0]      io_wdata,
  output logic            io_wr,
  output logic            io_rd
);
  // Idle bus at time zero
  initial begin
    io_addr = 10'h000;
    io_wdata = 8'h00;
    io_wr = 1'h0;
    io_rd = 1'h0;
  end
  // One access, then the released bus shows inverted junk
  task automatic acc(input logic [9:0] a, input logic [7:0] d, input logic w);
    @(negedge clk_sys);
    io_addr = a;
    io_wdata = d;
    io_wr = w;
    io_rd = !w;
    @(negedge clk_sys);
    io_wr = 1'h0;
    io_rd = 1'h0;
    io_addr = ~a;
    io_wdata = ~d;
  endtask
  // Two key writes with nothing between, as if interrupts masked
  task automatic key(input logic [9:0] a);
    acc(a, `CFGUL_KEY_ENTER, 1'h1);
    acc(a, `CFGUL_KEY_ENTER, 1'h1);
  endtask
endmodule

// >>> sim/cfgul_gate_test.sv
// Self-checking bench of the configuration port unlock gate
`timescale 1ns/1ps
`include "cfgul_cfg.svh"
module cfgul_gate_test;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  logic               clk_sys = 1'h0;
  logic               rst_b = 1'h0;
  logic               strap = 1'h0;
  logic [9:0]         io_addr;
  logic [7:0]         io_wdata;
  logic               io_wr;
  logic               io_rd;
  logic [7:0]         rdata;
  logic               rvalid;
  logic               mode;
  logic               alt;
  logic               clk_en = 1'h1;
  logic [7:0]         idx;
  logic [8*42-1:0]    regs;
  int                 miscompares = 0;
  int                 n_tests = 0;
  cfgul_host i_cfgul_host (.clk_sys(clk_sys), .io_addr(io_addr), .io_wdata(io_wdata),
    .io_wr(io_wr), .io_rd(io_rd));
  cfgul_gate #(.NREG(42)) i_cfgul_gate (.clk_sys(clk_sys), .rst_b(rst_b), .clk_en(clk_en),
    .config_base_strap(strap), .io_addr(io_addr), .io_wdata(io_wdata), .io_wr(io_wr),
    .io_rd(io_rd), .io_rdata_q(rdata), .io_rvalid_q(rvalid), .cfg_mode_q(mode),
    .base_alt_q(alt), .cfg_index_q(idx), .config_register_set(regs));
  // Clock of 8 ns
  initial begin
    forever #4 clk_sys = ~clk_sys;
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic rst(input logic s);
    rst_b = 1'h0;
    strap = s;
    repeat (2) @(negedge clk_sys);
    rst_b = 1'h1;
    @(negedge clk_sys);
  endtask
  task automatic tally_and_finish;
    if (miscompares == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_locked;
    i_cfgul_host.acc(`CFGUL_IDX_PRI, 8'h00, 1'h1);
    i_cfgul_host.acc(`CFGUL_DAT_PRI, 8'h3f, 1'h1);
    chk("reg0", regs[7:0], 8'h00);
    i_cfgul_host.acc(`CFGUL_DAT_PRI, 8'h00, 1'h0);
    chk("rvalid", {7'h00, rvalid}, 8'h00);
  endtask
  task automatic t_key;
    i_cfgul_host.key(`CFGUL_IDX_ALT);
    chk("mode", {7'h00, mode}, 8'h00);
    i_cfgul_host.acc(`CFGUL_IDX_PRI, 8'h55, 1'h1);
    i_cfgul_host.acc(10'h3f2, 8'h00, 1'h1);
    i_cfgul_host.acc(`CFGUL_IDX_PRI, 8'h55, 1'h1);
    chk("mode", {7'h00, mode}, 8'h00);
    i_cfgul_host.acc(`CFGUL_IDX_PRI, 8'h55, 1'h1);
    chk("mode", {7'h00, mode}, 8'h01);
  endtask
  // Unlocked, program, then lock again
  task automatic t_prog;
    i_cfgul_host.acc(`CFGUL_IDX_PRI, 8'h00, 1'h1);
    i_cfgul_host.acc(`CFGUL_DAT_PRI, 8'h3f, 1'h1);
    chk("reg0", regs[7:0], 8'h3f);
    i_cfgul_host.acc(`CFGUL_IDX_PRI, 8'h29, 1'h1);
    i_cfgul_host.acc(`CFGUL_DAT_PRI, 8'h5a, 1'h1);
    chk("reg29", regs[8*41 +: 8], 8'h5a);
    i_cfgul_host.acc(`CFGUL_DAT_PRI, 8'h00, 1'h0);
    chk("rdata", rvalid ? rdata : 8'hee, 8'h5a);
    i_cfgul_host.acc(`CFGUL_IDX_PRI, 8'h2a, 1'h1);
    i_cfgul_host.acc(`CFGUL_DAT_PRI, 8'h66, 1'h1);
    chk("reg29", regs[8*41 +: 8], 8'h5a);
    i_cfgul_host.acc(`CFGUL_DAT_PRI, 8'h77, 1'h0);
    chk("rdata", rdata, 8'h00);
    chk("rvalid", {7'h00, rvalid}, 8'h01);
    // Exit key while frozen is not taken
    clk_en = 1'h0;
    i_cfgul_host.acc(`CFGUL_IDX_PRI, `CFGUL_KEY_EXIT, 1'h1);
    clk_en = 1'h1;
    chk("mode", {7'h00, mode}, 8'h01);
    i_cfgul_host.acc(`CFGUL_IDX_PRI, `CFGUL_KEY_EXIT, 1'h1);
    chk("mode", {7'h00, mode}, 8'h00);
    chk("index", idx, 8'h2a);
  endtask
  task automatic t_rst;
    i_cfgul_host.acc(`CFGUL_IDX_PRI, 8'h55, 1'h1);
    rst(1'h0);
    i_cfgul_host.acc(`CFGUL_IDX_PRI, 8'h55, 1'h1);
    chk("mode", {7'h00, mode}, 8'h00);
    chk("reg29", regs[8*41 +: 8], 8'h00);
  endtask
  task automatic t_alt;
    rst(1'h1);
    strap = 1'h0;
    i_cfgul_host.key(`CFGUL_IDX_PRI);
    chk("mode", {7'h00, mode}, 8'h00);
    i_cfgul_host.key(`CFGUL_IDX_ALT);
    i_cfgul_host.acc(`CFGUL_IDX_ALT, 8'h01, 1'h1);
    i_cfgul_host.acc(`CFGUL_DAT_ALT, 8'h9f, 1'h1);
    chk("reg1", regs[15:8], 8'h9f);
    chk("alt", {7'h00, alt}, 8'h01);
  endtask
  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    rst(1'h0);
    chk("mode", {7'h00, mode}, 8'h00);
    chk("alt", {7'h00, alt}, 8'h00);
    t_locked();
    t_key();
    t_prog();
    t_rst();
    t_alt();
    tally_and_finish();
  end
  initial begin
    #20000;
    miscompares++;
    tally_and_finish();
  end
endmodule
